/* rtl/acc_load_params.svh */
// constants for the accumulator load decoder: opcodes, field positions, reset values
// assumes a 10-bit instruction word and a 4-bit data path
`ifndef ACC_LOAD_PARAMS_SVH
`define ACC_LOAD_PARAMS_SVH

// instruction word and data widths
`define INSTR_W            10
`define DATA_W             4

// opcodes of the five accumulator loads
`define OP_LOAD_IC_TWO     10'h055
`define OP_LOAD_TC_ONE     10'h24b
`define OP_LOAD_TC_TWO     10'h24c
`define OP_LOAD_TC_SIX     10'h250
`define OP_LOAD_RAM_COL    10'h052

// one-hot source select bit positions
`define SRC_BIT_NONE       0
`define SRC_BIT_IC_TWO     1
`define SRC_BIT_TC_ONE     2
`define SRC_BIT_TC_TWO     3
`define SRC_BIT_TC_SIX     4
`define SRC_BIT_RAM_COL    5

// reset values
`define ACC_RST            4'h0
`define CARRY_RST          1'b0
`define OPCODE_RST         10'h000
`define RETIRE_CNT_RST     16'h0000

// every handled instruction takes one word and one cycle
`define LOAD_WORDS         1
`define LOAD_CYCLES        1

`endif

/* rtl/acc_load_pkg.sv */
// types shared by the accumulator load decoder and its opcode classifier
// assumes acc_load_params.svh is on the include path
`include "acc_load_params.svh"

package acc_load_pkg;

  // one-hot source selection for the accumulator
  typedef enum logic [5:0] {
    SRC_NONE    = 6'b000001,
    SRC_IC_TWO  = 6'b000010,
    SRC_TC_ONE  = 6'b000100,
    SRC_TC_TWO  = 6'b001000,
    SRC_TC_SIX  = 6'b010000,
    SRC_RAM_COL = 6'b100000
  } acc_src_t;

  // contents of every register that may feed the accumulator
  typedef struct packed {
    logic [`DATA_W-1:0] interrupt_control_two;
    logic [`DATA_W-1:0] timer_control_one;
    logic [`DATA_W-1:0] timer_control_two;
    logic [`DATA_W-1:0] timer_control_six;
    logic [`DATA_W-1:0] ram_column_reg;
  } src_regs_t;

  // instruction fetched from program memory
  typedef struct packed {
    logic               valid;
    logic [`INSTR_W-1:0] word;
  } instr_t;

  // result of classifying one instruction word
  typedef struct packed {
    logic     hit;
    acc_src_t src;
  } decode_t;

  // write from the rest of the core for instructions not handled here
  typedef struct packed {
    logic               acc_we;
    logic [`DATA_W-1:0] acc_data;
    logic               carry_we;
    logic               carry_data;
    logic               skip_req;
  } core_wr_t;

endpackage

/* rtl/opcode_classifier.sv */
// opcode classifier: maps a 10-bit instruction word to an accumulator source
// assumes acc_load_pkg is compiled first; purely combinational
`timescale 1ns/100ps
`include "acc_load_params.svh"

module opcode_classifier (
  // instruction in
  input  wire logic [`INSTR_W-1:0]   word,
  // classification out
  output acc_load_pkg::decode_t      dec
);
  import acc_load_pkg::*;

  // full 10-bit compare, no partial decode
  function automatic decode_t classify(input logic [`INSTR_W-1:0] w);
    decode_t r;
    r.hit = 1'b1;
    case (w)
      `OP_LOAD_IC_TWO:  r.src = SRC_IC_TWO;
      `OP_LOAD_TC_ONE:  r.src = SRC_TC_ONE;
      `OP_LOAD_TC_TWO:  r.src = SRC_TC_TWO;
      `OP_LOAD_TC_SIX:  r.src = SRC_TC_SIX;
      `OP_LOAD_RAM_COL: r.src = SRC_RAM_COL;
      default: begin
        r.hit = 1'b0;
        r.src = SRC_NONE;
      end
    endcase
    return r;
  endfunction

  // decode the word as it stands
  always_comb begin
    dec = classify(word);
  end

endmodule

/* rtl/accumulator_load_decode.sv */
// accumulator load decoder: five single-word loads of the 4-bit accumulator
// a core write in a cycle with a handled load is dropped, not queued
// assumes instruction words arrive synchronous to clk_sys, one per cycle at most
// assumes src_regs show each register's current contents in the cycle the word is taken
//
// Behaviour
// RULE_01: opcode 1001001011 loads all four accumulator bits from timer control one.
// RULE_02: opcode 1001001100 loads the accumulator from timer control two.
// RULE_03: opcode 1001010000 loads the accumulator from timer control six.
// RULE_04: opcode 052 hex loads the accumulator from register X.
// RULE_05: a distinct opcode loads the accumulator from interrupt control two.
// RULE_06: reading timer control six returns its value and leaves it unchanged.
// RULE_07: each load is one word, one cycle, keeps carry, never skips.
`timescale 1ns/100ps
`include "acc_load_params.svh"

module accumulator_load_decode (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  // instruction from program memory
  input  acc_load_pkg::instr_t             instr,
  // register contents that may be copied
  input  acc_load_pkg::src_regs_t          src_regs,
  // writes from the rest of the core
  input  acc_load_pkg::core_wr_t           core_wr,
  // architectural state
  output logic [`DATA_W-1:0]               acc_q,
  output logic                             carry_flag_q,
  // per-instruction results
  output logic                             load_done_q,
  output logic                             skip_next_q,
  output acc_load_pkg::acc_src_t           src_q,
  output logic [`INSTR_W-1:0]              last_opcode_q,
  output logic                             tc_six_read_q,
  output logic                             unhandled_q,
  output logic [15:0]                      retire_cnt_q
);
  import acc_load_pkg::*;

  decode_t             dec;
  logic                take;
  logic [`DATA_W-1:0]  sel_data;
  logic [`DATA_W-1:0]  acc_d;
  logic                carry_d;
  logic                skip_d;
  logic                done_d;
  acc_src_t            src_d;
  logic                tc_six_rd_d;
  logic                unhandled_d;
  logic [`INSTR_W-1:0] opcode_d;
  logic [15:0]         cnt_d;

  // classify the incoming word
  opcode_classifier u_classify (
    .word (instr.word),
    .dec  (dec)
  );

  // a word is acted on only when valid and recognised
  assign take = instr.valid & dec.hit;

  // pick the source register, full four bits each
  function automatic logic [`DATA_W-1:0] pick(input acc_src_t s, input src_regs_t r,
                                              input logic [`DATA_W-1:0] keep);
    logic [`DATA_W-1:0] v;
    v = keep;
    case (s)
      SRC_IC_TWO:  v = r.interrupt_control_two;  // see RULE_05
      SRC_TC_ONE:  v = r.timer_control_one;      // see RULE_01
      SRC_TC_TWO:  v = r.timer_control_two;      // see RULE_02
      SRC_TC_SIX:  v = r.timer_control_six;      // see RULE_03
      SRC_RAM_COL: v = r.ram_column_reg;         // see RULE_04
      SRC_NONE:    v = keep;
      default:     v = keep;
    endcase
    return v;
  endfunction

  // source mux, a pure read of the selected register
  always_comb begin
    sel_data = pick(dec.src, src_regs, acc_q);  // see RULE_06
  end

  // accumulator next value: a handled load wins over a core write
  always_comb begin
    acc_d = acc_q;
    if (take) begin
      acc_d = sel_data;
    end else if (core_wr.acc_we) begin
      acc_d = core_wr.acc_data;
    end
  end

  // carry is never written by a handled load
  always_comb begin
    carry_d = carry_flag_q;
    if (!take && core_wr.carry_we) begin  // see RULE_07
      carry_d = core_wr.carry_data;
    end
  end

  // skip of the next word is suppressed for a handled load
  always_comb begin
    skip_d = 1'b0;
    if (!take) begin  // see RULE_07
      skip_d = core_wr.skip_req;
    end
  end

  // per-instruction pulses low and src_d at SRC_NONE unless a word is acted on
  always_comb begin
    done_d      = take;  // see RULE_07
    src_d       = SRC_NONE;
    tc_six_rd_d = 1'b0;
    if (take) begin
      src_d       = dec.src;
      tc_six_rd_d = (dec.src == SRC_TC_SIX);  // see RULE_06
    end
  end

  // valid word outside the five loads, left to the rest of the core
  always_comb begin
    unhandled_d = instr.valid & ~dec.hit;
  end

  // opcode record moves only on a handled load
  always_comb begin
    opcode_d = last_opcode_q;
    if (take) begin
      opcode_d = instr.word;
    end
  end

  // retire count, wraps at all ones
  always_comb begin
    cnt_d = retire_cnt_q;
    if (take) begin
      cnt_d = retire_cnt_q + 16'h0001;
    end
  end

  // accumulator register, updated in the same cycle the word is taken
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc_q <= `ACC_RST;
    end else begin
      acc_q <= acc_d;  // see RULE_07
    end
  end

  // carry flag
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      carry_flag_q <= `CARRY_RST;
    end else begin
      carry_flag_q <= carry_d;
    end
  end

  // skip request towards the fetch stage
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      skip_next_q <= 1'b0;
    end else begin
      skip_next_q <= skip_d;
    end
  end

  // one-cycle completion pulse
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      load_done_q <= 1'b0;
    end else begin
      load_done_q <= done_d;  // see RULE_07
    end
  end

  // source record, one cycle per load
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      src_q <= SRC_NONE;
    end else begin
      src_q <= src_d;
    end
  end

  // read strobe for timer control six, no write path back to it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tc_six_read_q <= 1'b0;
    end else begin
      tc_six_read_q <= tc_six_rd_d;  // see RULE_06
    end
  end

  // valid word that is not one of the five loads
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      unhandled_q <= 1'b0;
    end else begin
      unhandled_q <= unhandled_d;
    end
  end

  // last opcode handled here
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      last_opcode_q <= `OPCODE_RST;
    end else begin
      last_opcode_q <= opcode_d;
    end
  end

  // count of handled loads, wraps
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      retire_cnt_q <= `RETIRE_CNT_RST;
    end else begin
      retire_cnt_q <= cnt_d;
    end
  end

endmodule

/* sim/prog_mem_model.sv */
// program memory model: presents one instruction word per cycle
// assumes the bench updates the next word just after each rising edge
`timescale 1ns/100ps
`include "acc_load_params.svh"

module prog_mem_model (
  // clock
  input  wire logic                clk_sys,
  // next word from the bench
  input  wire logic                nxt_valid,
  input  wire logic [`INSTR_W-1:0] nxt_word,
  // word to the decoder
  output acc_load_pkg::instr_t     instr
);
  logic [`INSTR_W-1:0] last_q = '0;

  // idle bus shows the inverse of the last word, never a stale copy
  always_ff @(posedge clk_sys) begin
    if (nxt_valid)
      last_q <= nxt_word;
  end
  assign instr = nxt_valid ? {1'b1, nxt_word} : {1'b0, ~last_q};
endmodule

/* sim/accumulator_load_decode_sva.sv */
// checker for the accumulator load decoder
// assumes it is bound to the decoder and sees only its ports
`timescale 1ns/100ps
`include "acc_load_params.svh"

module accumulator_load_decode_sva (
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    rstn,
  // observed ports
  input acc_load_pkg::instr_t         instr,
  input acc_load_pkg::src_regs_t      src_regs,
  input wire logic [`DATA_W-1:0]      acc_q,
  input wire logic                    carry_flag_q,
  input wire logic                    load_done_q,
  input wire logic                    skip_next_q,
  input acc_load_pkg::acc_src_t       src_q,
  input wire logic                    tc_six_read_q
);
  import acc_load_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic hit;

  // a handled load taken this cycle
  assign hit = instr.valid && (instr.word inside {`OP_LOAD_IC_TWO, `OP_LOAD_TC_ONE,
    `OP_LOAD_TC_TWO, `OP_LOAD_TC_SIX, `OP_LOAD_RAM_COL});

  property p_ld(logic [9:0] op, logic [3:0] v);
    instr.valid && instr.word == op |=> acc_q == $past(v);
  endproperty
  AST_TC_ONE: assert property (p_ld(`OP_LOAD_TC_ONE, src_regs.timer_control_one))
    else $error("acc not loaded from timer control one");
  AST_TC_TWO: assert property (p_ld(`OP_LOAD_TC_TWO, src_regs.timer_control_two))
    else $error("acc not loaded from timer control two");
  AST_TC_SIX: assert property (p_ld(`OP_LOAD_TC_SIX, src_regs.timer_control_six))
    else $error("acc not loaded from timer control six");
  AST_RAM_COL: assert property (p_ld(`OP_LOAD_RAM_COL, src_regs.ram_column_reg))
    else $error("acc not loaded from register x");
  AST_IC_TWO: assert property (p_ld(`OP_LOAD_IC_TWO, src_regs.interrupt_control_two))
    else $error("acc not loaded from interrupt control two");
  AST_TC_SIX_READ: assert property (instr.valid && instr.word == `OP_LOAD_TC_SIX |=>
    tc_six_read_q && src_q == SRC_TC_SIX) else $error("timer control six read not flagged");
  AST_KEEP_CARRY: assert property (hit |=> $stable(carry_flag_q))
    else $error("carry changed by a load");
  AST_NO_SKIP: assert property (hit |=> load_done_q && !skip_next_q)
    else $error("load not done in one cycle or skip raised");
  AST_ONE_PULSE: assert property (hit ##1 !hit |=> !load_done_q)
    else $error("load done pulse too long");

  // main scenarios
  cover property (hit ##1 hit);
  cover property (load_done_q && src_q == SRC_RAM_COL);
  cover property (instr.valid && !hit);
endmodule

bind accumulator_load_decode accumulator_load_decode_sva i_sva (.clk_sys, .rstn, .instr,
  .src_regs, .acc_q, .carry_flag_q, .load_done_q, .skip_next_q, .src_q, .tc_six_read_q);

/* sim/accumulator_load_decode_tb_top.sv */
// bench top: table and random instruction stream against a reference model
// assumes the design, the program memory model and the checker are compiled first
`timescale 1ns/100ps
`include "acc_load_params.svh"

module accumulator_load_decode_tb_top;
  import acc_load_pkg::*;
  logic clk_sys = 1'b0, rstn = 1'b0, nxt_valid = 1'b0;
  logic [9:0] nxt_word = 10'h000, last_opcode_q;
  instr_t instr;
  src_regs_t src_regs = '0;
  core_wr_t core_wr = '0;
  logic [3:0] acc_q, e_acc;
  logic carry_flag_q, load_done_q, skip_next_q, tc_six_read_q, unhandled_q, e_carry;
  logic [9:0] e_op;
  acc_src_t src_q;
  logic [15:0] retire_cnt_q, e_cnt;
  int bad_count = 0, num_checks = 0;
  logic [31:0] seed = 32'h89d9b805;
  logic [9:0] ops [5] = '{`OP_LOAD_IC_TWO, `OP_LOAD_TC_ONE, `OP_LOAD_TC_TWO,
    `OP_LOAD_TC_SIX, `OP_LOAD_RAM_COL};
  acc_src_t srcs [5] = '{SRC_IC_TWO, SRC_TC_ONE, SRC_TC_TWO, SRC_TC_SIX, SRC_RAM_COL};

  always #2.5 clk_sys = ~clk_sys;

  prog_mem_model i_mem (.clk_sys, .nxt_valid, .nxt_word, .instr);
  accumulator_load_decode i_dut (.clk_sys, .rstn, .instr, .src_regs, .core_wr, .acc_q,
    .carry_flag_q, .load_done_q, .skip_next_q, .src_q, .last_opcode_q, .tc_six_read_q,
    .unhandled_q, .retire_cnt_q);

  task automatic test_done();
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction

  // reference accumulator and carry after one cycle: a handled load wins over core writes
  function automatic logic [4:0] ref_next(logic hit, int k, src_regs_t r, core_wr_t c,
                                          logic [4:0] cur);
    logic [4:0] n;
    n = cur;
    if (hit)
      n[4:1] = r[19-4*k -: 4];
    else begin
      if (c.acc_we)
        n[4:1] = c.acc_data;
      if (c.carry_we)
        n[0] = c.carry_data;
    end
    return n;
  endfunction

  task automatic do_reset();
    rstn = 1'b0;
    nxt_valid = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 rstn = 1'b1;
    e_acc = `ACC_RST;
    e_carry = `CARRY_RST;
    e_cnt = `RETIRE_CNT_RST;
    e_op = `OPCODE_RST;
    check("reset", {acc_q, carry_flag_q, src_q, retire_cnt_q}, {e_acc, e_carry, SRC_NONE, e_cnt});
    check("reset pulses", {last_opcode_q, load_done_q, skip_next_q, tc_six_read_q, unhandled_q},
      {e_op, 4'h0});
  endtask

  // one instruction cycle with random register contents and core writes
  task automatic step(logic v, logic [9:0] w);
    int k;
    logic hit;
    k = 0;
    hit = 1'b0;
    seed = xs(seed);
    src_regs = seed[19:0];
    seed = xs(seed);
    core_wr = seed[7:0];
    nxt_valid = v;
    nxt_word = w;
    for (int i = 0; i < 5; i++)
      if (v && w == ops[i]) begin
        hit = 1'b1;
        k = i;
      end
    @(posedge clk_sys);
    #1;
    {e_acc, e_carry} = ref_next(hit, k, src_regs, core_wr, {e_acc, e_carry});
    if (hit)
      e_op = w;
    e_cnt += hit;
    check("acc", acc_q, e_acc);
    check("flags", {carry_flag_q, load_done_q, skip_next_q, unhandled_q},
      {e_carry, hit, !hit && core_wr.skip_req, v && !hit});
    check("src", {src_q, tc_six_read_q}, {hit ? srcs[k] : SRC_NONE, hit && k == 3});
    check("count", retire_cnt_q, e_cnt);
    check("opcode", last_opcode_q, e_op);
  endtask

  initial begin
    do_reset();
    foreach (ops[i]) step(1'b1, ops[i]);
    foreach (ops[i]) step(1'b1, ops[4-i]);
    for (int n = 0; n < 400; n++) begin
      seed = xs(seed);
      step(seed[31], seed[30] ? ops[seed[2:0] % 5] : seed[9:0]);
    end
    do_reset();
    step(1'b1, `OP_LOAD_TC_SIX);
    test_done();
  end

  // watchdog against a hung run
  initial begin
    #10000;
    bad_count++;
    test_done();
  end
endmodule
